// ===== rtl/sbqf_regs.vh
// sbqf_regs.vh: register indices, field positions, reset values and timing
// counts for the servo biquad filter bank; definitions only
`ifndef SBQF_REGS_VH
`define SBQF_REGS_VH

// register indices, byte address is four times the index
`define SBQF_IDX_TF_OFFSET 8'h65
`define SBQF_IDX_VEL_OFFSET 8'h67
`define SBQF_IDX_ENABLE 8'h70
`define SBQF_IDX_CONFIG 8'h71
`define SBQF_IDX_STATUS 8'h72
// coefficient index = base + channel * 8 + tap
`define SBQF_IDX_COEF_BASE 8'h80

// config fields
`define SBQF_CFG_STDV_BIT 0
`define SBQF_CFG_DS_LSB 8
`define SBQF_CFG_DS_MSB 15

// channels and taps
`define SBQF_NUM_CH 5
`define SBQF_NUM_TAP 5
`define SBQF_CH_POS 3'd0
`define SBQF_CH_FLUX 3'd1
`define SBQF_CH_TORQUE 3'd2
`define SBQF_CH_VEL 3'd3
`define SBQF_CH_VACT 3'd4
`define SBQF_FRAC_BITS 29

// coefficient reset values, taps b0 b1 b2 a1 a2
`define SBQF_COEF_ONE 32'h2000_0000
`define SBQF_LP_B0 32'h0004_FEF6
`define SBQF_LP_B1 32'h0009_FDEC
`define SBQF_LP_A1 32'h3DB9_E8C4
`define SBQF_LP_A2 32'hE232_1C48

// standard velocity filter: first order, 20 Hz at its sample rate
`define SBQF_STDV_ALPHA 17'h0_0742
`define SBQF_CLK_PERIOD_NS 50
`define SBQF_STDV_PERIOD_NS 228882

`endif

// ===== rtl/sbqf_filter_bank.v
// sbqf_filter_bank.v: bank of five biquad filters with offsets and a
// standard velocity low-pass, registers over a classic wishbone slave.
// assumes pwm_tick is a one-cycle pulse per modulation period from logic
// on clk_sys, and that all target inputs come from the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "sbqf_regs.vh"

module sbqf_filter_bank #(
  parameter STDV_DIV = `SBQF_STDV_PERIOD_NS / `SBQF_CLK_PERIOD_NS
) (
  input wire clk_sys,
  input wire rst_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [9:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire pwm_tick,
  input wire [31:0] pos_target_i,
  input wire [31:0] flux_target_i,
  input wire [31:0] torque_target_i,
  input wire [31:0] vel_target_i,
  input wire [31:0] vel_meas_i,
  output reg [31:0] pos_target_o,
  output reg [31:0] flux_target_o,
  output reg [31:0] torque_target_o,
  output reg [31:0] vel_target_o,
  output reg [31:0] vel_actual_o,
  output reg filt_valid_o
);

  localparam ST_IDLE = 2'd0;
  localparam ST_MAC = 2'd1;
  localparam ST_DONE = 2'd2;

  reg [31:0] coef_q [0:24];
  reg [31:0] x1_q [0:4];
  reg [31:0] x2_q [0:4];
  reg [31:0] y1_q [0:4];
  reg [31:0] y2_q [0:4];
  reg [31:0] xin_q [0:4];
  reg [31:0] res_q [0:4];
  reg [31:0] tf_off_q;
  reg [31:0] vel_off_q;
  reg [4:0] en_q;
  reg [31:0] cfg_q;
  reg [1:0] st_q;
  reg [2:0] ch_q;
  reg [2:0] tap_q;
  reg [4:0] pend_q;
  reg [67:0] acc_q;
  reg [7:0] ds_cnt_q;
  reg [12:0] stdv_cnt_q;
  reg [31:0] stdv_q;
  reg [31:0] rd_d;
  reg [31:0] samp_d;
  reg [4:0] clr_d;
  wire [7:0] idx = wb_adr_i[9:2];
  wire wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  wire [63:0] prod = $signed(coef_q[ch_q * 5 + tap_q]) * $signed(samp_d);
  wire [67:0] acc_d = acc_q + {{4{prod[63]}}, prod};
  wire [67:0] acc_sh = {{29{acc_q[67]}}, acc_q[67:29]};
  wire [32:0] stdv_diff = {vel_meas_i[31], vel_meas_i} - {stdv_q[31], stdv_q};
  wire [49:0] stdv_prod = $signed(stdv_diff) * $signed(`SBQF_STDV_ALPHA);
  integer i;

  // clip a wide signed value into 32 bits
  function [31:0] sat32;
    input [67:0] v;
    begin
      if (v[67:31] == {37{1'b0}} || v[67:31] == {37{1'b1}})
        sat32 = v[31:0];
      else if (v[67])
        sat32 = 32'h8000_0000;
      else
        sat32 = 32'h7FFF_FFFF;
    end
  endfunction

  // true when the index addresses a used coefficient slot
  function is_coef;
    input [7:0] a;
    begin
      is_coef = a[7] && (a[6:3] < `SBQF_NUM_CH) && (a[2:0] < `SBQF_NUM_TAP);
    end
  endfunction

  // byte-lane merge of a write into an old word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0] sel;
    begin
      merge = (old & ~{{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}})
        | (dat & {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}});
    end
  endfunction

  always @*
  begin
    case (tap_q)
      3'd0: samp_d = xin_q[ch_q];
      3'd1: samp_d = x1_q[ch_q];
      3'd2: samp_d = x2_q[ch_q];
      3'd3: samp_d = y1_q[ch_q];
      default: samp_d = y2_q[ch_q];
    endcase
  end

  // channels whose parameters this write touches
  always @*
  begin
    clr_d = 5'd0;
    if (wr_en && is_coef(idx))
      clr_d[idx[5:3]] = 1'b1;
    if (wr_en && idx == `SBQF_IDX_ENABLE && wb_sel_i[0])
      clr_d = wb_dat_i[4:0] ^ en_q;
  end

  // register read mux, unmapped reads zero
  always @*
  begin
    rd_d = 32'h0000_0000;
    if (is_coef(idx))
      rd_d = coef_q[idx[5:3] * 5 + idx[2:0]];
    else if (idx == `SBQF_IDX_TF_OFFSET)
      rd_d = tf_off_q;
    else if (idx == `SBQF_IDX_VEL_OFFSET)
      rd_d = vel_off_q;
    else if (idx == `SBQF_IDX_ENABLE)
      rd_d = {27'd0, en_q};
    else if (idx == `SBQF_IDX_CONFIG)
      rd_d = cfg_q;
    else if (idx == `SBQF_IDX_STATUS)
      rd_d = {pend_q, 2'd0, ds_cnt_q, 13'd0, ch_q, (st_q != ST_IDLE)};
  end

  // wishbone slave: registered answer after one wait state, ack dropped after one cycle
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      tf_off_q <= 32'h0000_0000;
      vel_off_q <= 32'h0000_0000;
      en_q <= 5'd0;
      cfg_q <= 32'h0000_0000;
      for (i = 0; i < 25; i = i + 1)
        coef_q[i] <= (i % 5 == 0) ? `SBQF_COEF_ONE : 32'h0000_0000;
      coef_q[20] <= `SBQF_LP_B0;
      coef_q[21] <= `SBQF_LP_B1;
      coef_q[22] <= `SBQF_LP_B0;
      coef_q[23] <= `SBQF_LP_A1;
      coef_q[24] <= `SBQF_LP_A2;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o)
        wb_dat_o <= rd_d;
      if (wr_en)
      begin
        if (is_coef(idx))
          coef_q[idx[5:3] * 5 + idx[2:0]] <=
            merge(coef_q[idx[5:3] * 5 + idx[2:0]], wb_dat_i, wb_sel_i);
        if (idx == `SBQF_IDX_TF_OFFSET)
          tf_off_q <= merge(tf_off_q, wb_dat_i, wb_sel_i);
        if (idx == `SBQF_IDX_VEL_OFFSET)
          vel_off_q <= merge(vel_off_q, wb_dat_i, wb_sel_i);
        if (idx == `SBQF_IDX_ENABLE && wb_sel_i[0])
          en_q <= wb_dat_i[4:0];
        if (idx == `SBQF_IDX_CONFIG)
          cfg_q <= merge(cfg_q, wb_dat_i, wb_sel_i) & 32'h0000_FF01;
      end
    end
  end

  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      stdv_cnt_q <= 13'd0;
      stdv_q <= 32'h0000_0000;
    end
    else if (stdv_cnt_q == STDV_DIV[12:0] - 13'd1)
    begin
      // new value once per divider period
      stdv_cnt_q <= 13'd0;
      stdv_q <= stdv_q + stdv_prod[47:16];
    end
    else
      stdv_cnt_q <= stdv_cnt_q + 13'd1;
  end

  // sequential multiply-accumulate engine over the five channels
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st_q <= ST_IDLE;
      ch_q <= 3'd0;
      tap_q <= 3'd0;
      pend_q <= 5'd0;
      acc_q <= 68'd0;
      ds_cnt_q <= 8'd0;
      filt_valid_o <= 1'b0;
      pos_target_o <= 32'h0000_0000;
      flux_target_o <= 32'h0000_0000;
      torque_target_o <= 32'h0000_0000;
      vel_target_o <= 32'h0000_0000;
      vel_actual_o <= 32'h0000_0000;
      for (i = 0; i < 5; i = i + 1)
      begin
        x1_q[i] <= 32'h0000_0000;
        x2_q[i] <= 32'h0000_0000;
        y1_q[i] <= 32'h0000_0000;
        y2_q[i] <= 32'h0000_0000;
        xin_q[i] <= 32'h0000_0000;
        res_q[i] <= 32'h0000_0000;
      end
    end
    else
    begin
      filt_valid_o <= 1'b0;
      case (st_q)
        ST_IDLE:
        begin
          if (pwm_tick)
          begin
            xin_q[0] <= pos_target_i;
            xin_q[1] <= flux_target_i;
            xin_q[2] <= torque_target_i;
            xin_q[3] <= vel_target_i;
            xin_q[4] <= cfg_q[`SBQF_CFG_STDV_BIT] ? stdv_q : vel_meas_i;
            ds_cnt_q <= (ds_cnt_q == 8'd0) ?
              cfg_q[`SBQF_CFG_DS_MSB:`SBQF_CFG_DS_LSB] : ds_cnt_q - 8'd1;
            pend_q <= {4'b1111, (ds_cnt_q == 8'd0)};
            ch_q <= 3'd0;
            tap_q <= 3'd0;
            acc_q <= 68'd0;
            st_q <= ST_MAC;
          end
        end
        ST_MAC:
        begin
          if (!pend_q[ch_q] || !en_q[ch_q])
          begin
            if (pend_q[ch_q])
              res_q[ch_q] <= xin_q[ch_q];
            ch_q <= ch_q + 3'd1;
            if (ch_q == `SBQF_CH_VACT)
              st_q <= ST_DONE;
          end
          else
          begin
            acc_q <= acc_d;
            if (tap_q == 3'd4)
            begin
              tap_q <= 3'd0;
              st_q <= ST_DONE;
            end
            else
              tap_q <= tap_q + 3'd1;
          end
        end
        ST_DONE:
        begin
          if (ch_q <= `SBQF_CH_VACT && en_q[ch_q] && pend_q[ch_q])
          begin
            res_q[ch_q] <= sat32(acc_sh);
            x1_q[ch_q] <= xin_q[ch_q];
            x2_q[ch_q] <= x1_q[ch_q];
            y1_q[ch_q] <= sat32(acc_sh);
            y2_q[ch_q] <= y1_q[ch_q];
            acc_q <= 68'd0;
            ch_q <= ch_q + 3'd1;
            st_q <= (ch_q == `SBQF_CH_VACT) ? ST_IDLE : ST_MAC;
            filt_valid_o <= (ch_q == `SBQF_CH_VACT);
          end
          else
          begin
            st_q <= ST_IDLE;
            filt_valid_o <= 1'b1;
          end
          pend_q <= (ch_q == `SBQF_CH_VACT || ch_q > `SBQF_CH_VACT) ? 5'd0 : pend_q;
        end
        default: st_q <= ST_IDLE;
      endcase
      // offsets added to targets, three target paths (flux, torque, velocity)
      pos_target_o <= res_q[0];
      flux_target_o <= sat32({{36{res_q[1][31]}}, res_q[1]}
        + {{52{tf_off_q[15]}}, tf_off_q[15:0]});
      torque_target_o <= sat32({{36{res_q[2][31]}}, res_q[2]}
        + {{52{tf_off_q[31]}}, tf_off_q[31:16]});
      vel_target_o <= sat32({{36{res_q[3][31]}}, res_q[3]}
        + {{36{vel_off_q[31]}}, vel_off_q});
      vel_actual_o <= res_q[4];
      // history clear wins over engine update
      for (i = 0; i < 5; i = i + 1)
        if (clr_d[i])
        begin
          x1_q[i] <= 32'h0000_0000;
          x2_q[i] <= 32'h0000_0000;
          y1_q[i] <= 32'h0000_0000;
          y2_q[i] <= 32'h0000_0000;
        end
    end
  end

endmodule // sbqf_filter_bank
`default_nettype wire

// ===== test/sbqf_cascade_model.sv
// sbqf_cascade_model.sv: cascade stand-in giving ticks and targets
// assumes the filter bank shares clk_sys and rst_n
`timescale 1ns/1ps
`default_nettype none
module sbqf_cascade_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic fire,
  input wire logic [31:0] val,
  output logic pwm_tick,
  output logic [31:0] tgt_o,
  output logic [31:0] meas_o
);
  logic pend_q;
  logic [5:0] gap_q;
  // one tick per period, spaced by 41 cycles
  always @(posedge clk_sys)
  begin
    pwm_tick <= 1'b0;
    if (!rst_n)
    begin
      pend_q <= 1'b0;
      gap_q <= 6'h00;
      tgt_o <= 32'h0000_0000;
      meas_o <= 32'h0000_0000;
    end
    else
    begin
      if (fire)
        pend_q <= 1'b1;
      if (gap_q != 6'h00)
        gap_q <= gap_q - 6'h01;
      else if (pend_q)
      begin
        pwm_tick <= 1'b1;
        pend_q <= 1'b0;
        gap_q <= 6'h28;
        tgt_o <= val;
        meas_o <= ~val;
      end
    end
  end
endmodule // sbqf_cascade_model
`default_nettype wire

// ===== test/sbqf_filter_bank_properties.sv
// sbqf_filter_bank_properties.sv: bus and pass timing checks
// assumes ticks at least 32 cycles apart
`timescale 1ns/1ps
`default_nettype none
module sbqf_filter_bank_properties #(
  parameter STDV_DIV = 20
) (
  input wire clk_sys,
  input wire rst_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [9:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire pwm_tick,
  input wire [31:0] torque_target_o,
  input wire filt_valid_o
);
  logic [5:0] cnt_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // cycles since the last tick, saturating
  always @(posedge clk_sys)
    if (!rst_n)
      cnt_q <= 6'h3f;
    else if (pwm_tick)
      cnt_q <= 6'h00;
    else if (cnt_q != 6'h3f)
      cnt_q <= cnt_q + 6'h01;
  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  property p_ack_resp;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("request not acked");
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_unmapped;
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i[9:2] == 8'h10
      |=> wb_dat_o == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rst_quiet;
    $rose(rst_n) |-> !wb_ack_o && !filt_valid_o && torque_target_o == 32'h0000_0000;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
  property p_tick_answer;
    pwm_tick |-> ##[4:32] filt_valid_o;
  endproperty
  a_tick_answer: assert property (p_tick_answer) else $error("pass did not end");
  property p_valid_window;
    filt_valid_o |-> cnt_q >= 6'd3 && cnt_q <= 6'd31;
  endproperty
  a_valid_window: assert property (p_valid_window) else $error("valid outside pass");
  property p_valid_once;
    filt_valid_o |=> !filt_valid_o;
  endproperty
  a_valid_once: assert property (p_valid_once) else $error("valid not a pulse");
endmodule // sbqf_filter_bank_properties
bind sbqf_filter_bank sbqf_filter_bank_properties #(.STDV_DIV(STDV_DIV)) i_props (
  .clk_sys, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
  .wb_ack_o, .pwm_tick, .torque_target_o, .filt_valid_o);
`default_nettype wire

// ===== test/sbqf_filter_bank_bench.sv
// sbqf_filter_bank_bench.sv: self-checking bench for the filter bank
// assumes the cascade model in front of the target inputs
`timescale 1ns/1ps
`default_nettype none
`include "sbqf_regs.vh"
module sbqf_filter_bank_bench;
  logic clk_sys = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, fire = 1'b0;
  logic [3:0] sel = 4'hf;
  logic [9:0] adr = 10'h000;
  logic [31:0] dat = 32'h0000_0000, val = 32'h0000_0000, off = 32'h0000_0000;
  wire [31:0] rdat, tgt, meas, pos_o, flux_o, tq_o, vel_o, vact_o;
  wire ack, tick, valid;
  logic signed [31:0] cf [5], x1, x2, y1, y2;
  logic en = 1'b0;
  logic [127:0] e;
  logic [31:0] rq [$];
  logic [127:0] fq [$];
  logic [31:0] pexp = 32'h0000_0000;
  logic [7:0] ds = 8'h00, dsc = 8'h00;
  logic [31:0] tap [5] = '{32'h1000_0000, 32'h0800_0000, 32'h0000_0000,
    32'h3000_0000, 32'hf000_0000};
  int err_count = 0, check_count = 0, cycles = 0;
  sbqf_cascade_model i_sbqf_cascade_model (.clk_sys(clk_sys), .rst_n(rst_n), .fire(fire),
    .val(val), .pwm_tick(tick), .tgt_o(tgt), .meas_o(meas));
  sbqf_filter_bank #(.STDV_DIV(20)) i_sbqf_filter_bank (.clk_sys(clk_sys), .rst_n(rst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .pwm_tick(tick),
    .pos_target_i(tgt), .flux_target_i(tgt), .torque_target_i(tgt), .vel_target_i(tgt),
    .vel_meas_i(meas), .pos_target_o(pos_o), .flux_target_o(flux_o),
    .torque_target_o(tq_o), .vel_target_o(vel_o), .vel_actual_o(vact_o),
    .filt_valid_o(valid));
  // clock and cycle limit
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      err_count++;
      summarize();
    end
  end
  task chk(input logic [31:0] a, input logic [31:0] b);
    check_count++;
    if (a !== b)
    begin
      err_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, a, b);
    end
  endtask
  task summarize;
    $display("checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  function automatic logic [31:0] sat(input logic signed [67:0] v);
    if (v > 68'sh7fff_ffff)
      return 32'h7fff_ffff;
    if (v < -68'sh8000_0000)
      return 32'h8000_0000;
    return v[31:0];
  endfunction
  // classic single cycle, released at the ack edge
  task bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat <= d;
    @(posedge clk_sys);
    while (ack !== 1'b1)
      @(posedge clk_sys);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task rd(input logic [7:0] idx, input logic [31:0] x);
    rq.push_back(x);
    bus(1'b0, idx, 32'h0000_0000);
  endtask
  task wr(input logic [7:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
    if (idx == 8'h65)
      off = d;
    if ((idx >= 8'h90 && idx <= 8'h94) || (idx == 8'h70 && d[2] != en))
      {x1, x2, y1, y2} = 128'h0;
    if (idx >= 8'h90 && idx <= 8'h94)
      cf[idx - 8'h90] = d;
    if (idx == 8'h70)
      en = d[2];
    if (idx == 8'h71)
      ds = d[15:8];
  endtask
  task pass(input logic [31:0] x);
    logic [31:0] y;
    y = en ? sat((cf[0] * $signed(x) + cf[1] * x1 + cf[2] * x2 + cf[3] * y1
      + cf[4] * y2) >>> 29) : x;
    {x2, x1, y2, y1} = {x1, x, y1, y};
    // position path only takes a new input every ds+1 ticks
    if (dsc == 8'h00)
    begin
      pexp = x;
      dsc = ds;
    end
    else
      dsc = dsc - 8'h01;
    fq.push_back({sat($signed(x) + $signed(off[15:0])),
      sat($signed(y) + $signed(off[31:16])), pexp, x});
    @(posedge clk_sys);
    val <= x;
    fire <= 1'b1;
    @(posedge clk_sys);
    fire <= 1'b0;
    repeat (90)
      if (fq.size() != 0)
        @(posedge clk_sys);
  endtask
  // read data against the oldest note
  always @(posedge clk_sys)
    if (ack === 1'b1 && we === 1'b0)
      chk(rdat, rq.pop_front());
  // filtered outputs two cycles after the valid pulse
  always @(posedge clk_sys)
    if (valid === 1'b1)
    begin
      repeat (2) @(posedge clk_sys);
      e = fq.pop_front();
      chk(pos_o, e[63:32]);
      chk(flux_o, e[127:96]);
      chk(tq_o, e[95:64]);
      chk(vel_o, e[31:0]);
      chk(vact_o, ~e[31:0]);
    end
  initial
  begin
    void'($urandom(74620));
    foreach (cf[i])
      cf[i] = (i == 0) ? `SBQF_COEF_ONE : 32'h0;
    {x1, x2, y1, y2} = 128'h0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(8'h70, 32'h0000_0000);
    rd(8'h80, `SBQF_COEF_ONE);
    rd(8'ha0, `SBQF_LP_B0);
    rd(8'ha1, `SBQF_LP_B1);
    rd(8'ha2, `SBQF_LP_B0);
    rd(8'ha3, `SBQF_LP_A1);
    rd(8'ha4, `SBQF_LP_A2);
    rd(8'h10, 32'h0000_0000);
    $display("test reset values done");
    wr(8'h65, $urandom);
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, 32'h0000_0000);
    rd(8'h65, off);
    repeat (3) pass($signed($urandom) >>> 2);
    $display("test pass-through and offsets done");
    wr(8'h65, 32'h0000_0000);
    // marginal pole set, negated feedback taps
    for (int i = 0; i < 5; i++)
      wr(8'(8'h90 + i), tap[i]);
    wr(8'h70, 32'h0000_0004);
    repeat (4) pass($signed($urandom) >>> 3);
    wr(8'h93, 32'h0800_0000);
    repeat (2) pass($signed($urandom) >>> 3);
    $display("test torque biquad done");
    wr(8'h90, 32'h7fff_ffff);
    pass(32'h7000_0000);
    pass(32'h9000_0000);
    $display("test saturation done");
    wr(8'h71, 32'h0000_0100);
    repeat (3) pass($signed($urandom) >>> 3);
    $display("test position down-sampling done");
    summarize();
  end
endmodule // sbqf_filter_bank_bench
`default_nettype wire
